// ### flash_status_read_path.sv
// status and non-array read path of a parallel flash behind its bus pins
// Behaviour
// - non-array reads work in async or sync burst mode and are always single-word reads.
// - an async page read of non-array data is valid only for the first word of the page.
// - a sync burst non-array read repeats the one word on each clock until the burst ends.
// - the status-read command is accepted at any address.
// - word program, block erase and block lock sequences enter the status state by themselves.
// - in the status state every read returns status until another valid command is written.
// - status goes on the low data byte and zero on the high byte.
// - in async mode the first falling edge of output enable or chip select latches status.
// - bit 7 of the status word is the device-wide write state.
// - bits 6 to 0 are erase suspended, erase, program, voltage, program suspended, lock, fast.
// - the status word defaults to all zero.
// - bit 7 reads 0 while a program or erase is in progress.
`timescale 1ns/1ps
module flash_status_read_path
    import flash_status_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic address_valid_n,
    input wire logic burst_clk,
    input wire logic [1:0] page_addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe,
    output logic word_valid,
    input wire logic sync_burst_mode,
    input wire logic [1:0] burst_len_sel,
    input wire logic [15:0] array_data,
    input wire logic [15:0] ident_data,
    input wire logic engine_busy,
    input wire logic erase_suspended_flag,
    input wire logic erase_result_flag,
    input wire logic program_result_flag,
    input wire logic program_voltage_flag,
    input wire logic program_suspended_flag,
    input wire logic locked_block_flag,
    input wire logic fast_program_state_flag,
    output logic program_start,
    output logic erase_start,
    output logic lock_start,
    output logic [7:0] operation_status_word
);
    pin_sync_if #(.WIDTH(PIN_WIDTH)) pins ();

    pin_sync #(.WIDTH(PIN_WIDTH)) u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pins(pins)
    );

    assign pins.raw = {dq_in, page_addr, burst_clk, address_valid_n, write_enable_n,
        output_enable_n, chip_select_n};

    logic s_ce_n;
    logic s_oe_n;
    logic s_we_n;
    logic s_adv_n;
    logic s_bclk;
    logic [1:0] s_addr;
    logic [15:0] s_dq;
    assign s_ce_n = pins.synced[PIN_CE];
    assign s_oe_n = pins.synced[PIN_OE];
    assign s_we_n = pins.synced[PIN_WE];
    assign s_adv_n = pins.synced[PIN_ADV];
    assign s_bclk = pins.synced[PIN_BCLK];
    assign s_addr = pins.synced[PIN_ADDR +: 2];
    assign s_dq = pins.synced[PIN_DQ +: 16];

    logic ce_prev_q, oe_prev_q, we_prev_q, adv_prev_q, bclk_prev_q;
    logic ce_fall, oe_fall, oe_rise, adv_fall, bclk_rise, we_rise, access;
    logic [7:0] cmd;

    // strobe history, one cycle behind the synchronised pins
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ce_prev_q <= 1'b1;
            oe_prev_q <= 1'b1;
            we_prev_q <= 1'b1;
            adv_prev_q <= 1'b1;
            bclk_prev_q <= 1'b0;
        end
        else
        begin
            ce_prev_q <= s_ce_n;
            oe_prev_q <= s_oe_n;
            we_prev_q <= s_we_n;
            adv_prev_q <= s_adv_n;
            bclk_prev_q <= s_bclk;
        end
    end

    // edge events; a write counts only while the chip is selected
    assign ce_fall = ce_prev_q & ~s_ce_n;
    assign oe_fall = oe_prev_q & ~s_oe_n;
    assign oe_rise = ~oe_prev_q & s_oe_n;
    assign adv_fall = adv_prev_q & ~s_adv_n;
    assign bclk_rise = ~bclk_prev_q & s_bclk;
    assign we_rise = ~we_prev_q & s_we_n & ~s_ce_n;
    assign access = ~s_ce_n & ~s_oe_n;
    assign cmd = s_dq[7:0];

    read_state_t state_q, state_d;
    logic prog_q, prog_d, erase_q, erase_d, lock_q, lock_d;

    // command decode; the address is never looked at, so any address is accepted
    always_comb
    begin
        state_d = state_q;
        prog_d = 1'b0;
        erase_d = 1'b0;
        lock_d = 1'b0;
        if (we_rise)
        begin
            case (state_q)
                ST_RD_ARRAY, ST_RD_STATUS, ST_RD_OTHER:
                begin
                    case (cmd)
                        CMD_READ_STATUS: state_d = ST_RD_STATUS;
                        CMD_READ_ARRAY: state_d = ST_RD_ARRAY;
                        CMD_READ_ID, CMD_QUERY: state_d = ST_RD_OTHER;
                        CMD_PROG_SETUP, CMD_PROG_ALT: state_d = ST_PROG_DATA;
                        CMD_ERASE_SETUP: state_d = ST_ERASE_CONF;
                        CMD_LOCK_SETUP: state_d = ST_LOCK_CONF;
                        default: state_d = state_q; // clear status and unknown codes keep the mode
                    endcase
                end
                // each sequence ends in the status state, even on a sequence error
                ST_PROG_DATA:
                begin
                    state_d = ST_RD_STATUS;
                    prog_d = 1'b1;
                end
                ST_ERASE_CONF:
                begin
                    state_d = ST_RD_STATUS;
                    erase_d = (cmd == CMD_CONFIRM);
                end
                ST_LOCK_CONF:
                begin
                    state_d = ST_RD_STATUS;
                    lock_d = 1'b1;
                end
                default: state_d = ST_RD_ARRAY;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_q <= ST_RD_ARRAY;
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            lock_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            prog_q <= prog_d;
            erase_q <= erase_d;
            lock_q <= lock_d;
        end
    end

    logic [7:0] status_live;
    logic [7:0] status_q, status_d;
    logic held_q, held_d, latch_ev;
    logic [1:0] page_q, page_d;

    // live status word; bit 7 low means an operation is running
    always_comb
    begin
        status_live = STATUS_RESET;
        status_live[WRITE_STATE_BIT] = ~engine_busy;
        status_live[ERASE_SUSPENDED_BIT] = erase_suspended_flag;
        status_live[ERASE_RESULT_BIT] = erase_result_flag;
        status_live[PROGRAM_RESULT_BIT] = program_result_flag;
        status_live[PROGRAM_VOLTAGE_BIT] = program_voltage_flag;
        status_live[PROGRAM_SUSPENDED_BIT] = program_suspended_flag;
        status_live[LOCKED_BLOCK_BIT] = locked_block_flag;
        status_live[FAST_PROGRAM_BIT] = fast_program_state_flag;
    end

    // snapshot so a changing engine cannot tear a word mid-read; a burst never refreshes
    always_comb
    begin
        if (sync_burst_mode)
            latch_ev = ce_fall | adv_fall;
        else
            latch_ev = (ce_fall | oe_fall) & ~held_q;
        held_d = held_q;
        if ((s_ce_n & s_oe_n) | oe_rise)
            held_d = 1'b0;
        if (latch_ev)
            held_d = 1'b1; // set wins over the clear
        status_d = latch_ev ? status_live : status_q;
        page_d = latch_ev ? s_addr : page_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            status_q <= STATUS_RESET;
            held_q <= 1'b0;
            page_q <= 2'h0;
        end
        else
        begin
            status_q <= status_d;
            held_q <= held_d;
            page_q <= page_d;
        end
    end

    logic [4:0] beat_q, beat_d, burst_len;
    logic [15:0] dq_out_q, dq_out_d;
    logic dq_oe_q, dq_oe_d, valid_q, valid_d, non_array;

    assign non_array = (state_q != ST_RD_ARRAY);

    // data drive, beat count and word validity
    always_comb
    begin
        case (burst_len_sel)
            2'h0: burst_len = BURST_LEN_4;
            2'h1: burst_len = BURST_LEN_8;
            default: burst_len = BURST_LEN_16;
        endcase
        beat_d = beat_q;
        if (ce_fall | adv_fall)
            beat_d = 5'h00;
        else if (access && bclk_rise && beat_q != 5'h1F)
            beat_d = beat_q + 5'h01;
        dq_oe_d = access;
        case (state_q)
            ST_RD_STATUS: dq_out_d = {STATUS_HIGH_BYTE, status_q};
            ST_RD_ARRAY: dq_out_d = array_data;
            default: dq_out_d = ident_data;
        endcase
        // a non-array read is one word: repeated in a burst, stale after a page step
        if (!access)
            valid_d = 1'b0;
        else if (sync_burst_mode)
            valid_d = (burst_len_sel == BURST_SEL_CONT) || (beat_q < burst_len);
        else
            valid_d = !non_array || (s_addr == page_q);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            beat_q <= 5'h00;
            dq_out_q <= 16'h0000;
            dq_oe_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else
        begin
            beat_q <= beat_d;
            dq_out_q <= dq_out_d;
            dq_oe_q <= dq_oe_d;
            valid_q <= valid_d;
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;
    assign word_valid = valid_q;
    assign program_start = prog_q;
    assign erase_start = erase_q;
    assign lock_start = lock_q;
    assign operation_status_word = status_q;

    sequence s_prog_data_write;
        state_q == ST_PROG_DATA && we_rise;
    endsequence

    sequence s_enter_status;
        state_q == ST_RD_STATUS && program_start;
    endsequence

    property p_status_byte_lanes;
        @(posedge clk_sys) disable iff (!rst_n)
        (access && state_q == ST_RD_STATUS) |=> dq_out == {8'h00, $past(status_q)};
    endproperty
    a_status_byte_lanes: assert property (p_status_byte_lanes)
        else $error("status not on low byte with zero high byte");

    property p_async_latch;
        @(posedge clk_sys) disable iff (!rst_n)
        (!sync_burst_mode && (ce_fall || oe_fall) && !held_q) |=> status_q == $past(status_live);
    endproperty
    a_async_latch: assert property (p_async_latch)
        else $error("status not latched on first strobe fall");

    property p_no_second_latch;
        @(posedge clk_sys) disable iff (!rst_n)
        (!sync_burst_mode && held_q && !ce_fall && !adv_fall) ##1 (held_q && oe_fall)
            |=> $stable(status_q);
    endproperty
    a_no_second_latch: assert property (p_no_second_latch)
        else $error("status relatched within one access");

    property p_burst_no_refresh;
        @(posedge clk_sys) disable iff (!rst_n)
        (sync_burst_mode && !ce_fall && !adv_fall) |=> $stable(status_q);
    endproperty
    a_burst_no_refresh: assert property (p_burst_no_refresh)
        else $error("status refreshed inside a burst");

    property p_busy_reads_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (latch_ev && engine_busy) |=> !operation_status_word[WRITE_STATE_BIT];
    endproperty
    a_busy_reads_zero: assert property (p_busy_reads_zero)
        else $error("write state bit not zero while busy");

    property p_prog_to_status;
        @(posedge clk_sys) disable iff (!rst_n)
        s_prog_data_write |=> s_enter_status ##1 !program_start;
    endproperty
    a_prog_to_status: assert property (p_prog_to_status)
        else $error("program sequence did not enter status state");

    property p_status_cmd_any_addr;
        @(posedge clk_sys) disable iff (!rst_n)
        (we_rise && cmd == CMD_READ_STATUS && state_q inside {ST_RD_ARRAY, ST_RD_OTHER})
            |=> state_q == ST_RD_STATUS;
    endproperty
    a_status_cmd_any_addr: assert property (p_status_cmd_any_addr)
        else $error("status command not accepted");

    property p_status_sticks;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_RD_STATUS && !we_rise) |=> state_q == ST_RD_STATUS;
    endproperty
    a_status_sticks: assert property (p_status_sticks)
        else $error("status state left without a command");

    property p_page_step_invalid;
        @(posedge clk_sys) disable iff (!rst_n)
        (!sync_burst_mode && access && non_array && s_addr != page_q) |=> !word_valid;
    endproperty
    a_page_step_invalid: assert property (p_page_step_invalid)
        else $error("later page word of non-array read marked valid");

    property p_burst_repeats;
        @(posedge clk_sys) disable iff (!rst_n)
        (sync_burst_mode && access && state_q == ST_RD_STATUS && !we_rise && !latch_ev)
            ##1 (access && bclk_rise && !we_rise && !latch_ev) |=> $stable(dq_out);
    endproperty
    a_burst_repeats: assert property (p_burst_repeats)
        else $error("burst word changed between beats");
endmodule : flash_status_read_path

// ### flash_status_pkg.sv
// constants, commands and read states of the flash status read path
package flash_status_pkg;
    // command codes seen on the low data byte at the rising write strobe
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;

    // status word layout
    localparam int WRITE_STATE_BIT = 7;
    localparam int ERASE_SUSPENDED_BIT = 6;
    localparam int ERASE_RESULT_BIT = 5;
    localparam int PROGRAM_RESULT_BIT = 4;
    localparam int PROGRAM_VOLTAGE_BIT = 3;
    localparam int PROGRAM_SUSPENDED_BIT = 2;
    localparam int LOCKED_BLOCK_BIT = 1;
    localparam int FAST_PROGRAM_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STATUS_HIGH_BYTE = 8'h00;

    // burst length selection and beat counts
    localparam logic [1:0] BURST_SEL_CONT = 2'h3;
    localparam logic [4:0] BURST_LEN_4 = 5'h04;
    localparam logic [4:0] BURST_LEN_8 = 5'h08;
    localparam logic [4:0] BURST_LEN_16 = 5'h10;

    // position of each pin in the synchroniser vector
    localparam int PIN_CE = 0;
    localparam int PIN_OE = 1;
    localparam int PIN_WE = 2;
    localparam int PIN_ADV = 3;
    localparam int PIN_BCLK = 4;
    localparam int PIN_ADDR = 5;
    localparam int PIN_DQ = 7;
    localparam int PIN_WIDTH = 23;

    typedef enum logic [2:0] {
        ST_RD_ARRAY = 3'h0,
        ST_RD_STATUS = 3'h1,
        ST_RD_OTHER = 3'h2,
        ST_PROG_DATA = 3'h3,
        ST_ERASE_CONF = 3'h4,
        ST_LOCK_CONF = 3'h5
    } read_state_t;
endpackage : flash_status_pkg

// ### pin_sync_if.sv
// carrier between the pin synchroniser and the read path
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport syncer (input raw, output synced);
    modport user (output raw, input synced);
endinterface : pin_sync_if

// ### pin_sync.sv
// two-flop synchroniser for the flash bus pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    pin_sync_if.syncer pins
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage feeds only the second stage; pins idle high (strobes inactive)
    always_comb
    begin
        meta_d = pins.raw;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meta_q <= '1;
            sync_q <= '1;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pins.synced = sync_q;
endmodule : pin_sync

// ### flash_host_model.sv
// host controller model that drives the flash bus pins
`timescale 1ns/1ps
module flash_host_model (
    input wire logic clk_sys,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic address_valid_n,
    output logic burst_clk,
    output logic [1:0] page_addr,
    output logic [15:0] dq_in,
    input wire logic [15:0] dq_out,
    input wire logic word_valid
);
    logic [16:0] beat_q [0:7]; // per beat: {word_valid, dq_out}

    // strobes idle high so reset releases with nothing selected
    initial
    begin
        chip_select_n = 1'b1;
        output_enable_n = 1'b1;
        write_enable_n = 1'b1;
        address_valid_n = 1'b1;
        burst_clk = 1'b0;
        page_addr = 2'h0;
        dq_in = 16'hFFFF;
    end

    // wait n clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // one command write; strobe low and high 3 clocks each to clear the synchroniser
    task wr(input logic [7:0] code, input logic [1:0] addr);
        chip_select_n <= 1'b0;
        page_addr <= addr;
        dq_in <= {8'h00, code};
        tick(1);
        write_enable_n <= 1'b0;
        tick(3);
        write_enable_n <= 1'b1;
        tick(3);
        chip_select_n <= 1'b1;
        page_addr <= 2'h0;
        dq_in <= ~{8'h00, code}; // released bus must not keep the last value
        tick(3);
    endtask : wr

    // async read; page address moves to pa2 after the first word
    task automatic rd(input logic [1:0] pa2, output logic [15:0] d, output logic v,
            output logic [15:0] d2, output logic v2);
        // select first, so the later enable fall meets an already held status word
        chip_select_n <= 1'b0;
        tick(3);
        output_enable_n <= 1'b0;
        tick(6);
        @(negedge clk_sys);
        d = dq_out;
        v = word_valid;
        @(posedge clk_sys);
        page_addr <= pa2;
        tick(4);
        @(negedge clk_sys);
        d2 = dq_out;
        v2 = word_valid;
        @(posedge clk_sys);
        chip_select_n <= 1'b1;
        output_enable_n <= 1'b1;
        page_addr <= 2'h0;
        tick(4);
    endtask : rd

    // sync burst of n beats; burst clock toggles only inside the select frame
    task automatic burst(input int n);
        chip_select_n <= 1'b0;
        address_valid_n <= 1'b0;
        tick(2);
        address_valid_n <= 1'b1;
        output_enable_n <= 1'b0;
        tick(6);
        @(negedge clk_sys);
        beat_q[0] = {word_valid, dq_out};
        for (int i = 1; i <= n; i++)
        begin
            @(posedge clk_sys);
            burst_clk <= 1'b1;
            tick(3);
            burst_clk <= 1'b0;
            tick(3);
            @(negedge clk_sys);
            beat_q[i] = {word_valid, dq_out};
        end
        @(posedge clk_sys);
        chip_select_n <= 1'b1;
        output_enable_n <= 1'b1;
        tick(4);
    endtask : burst
endmodule : flash_host_model

// ### tb_flash_status_read_path.sv
// self-checking testbench of the flash status read path
`timescale 1ns/1ps
module tb_flash_status_read_path
    import flash_status_pkg::*;
;
    localparam logic [15:0] ARRAY_WORD = 16'hA5C3;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic chip_select_n, output_enable_n, write_enable_n, address_valid_n, burst_clk;
    logic [1:0] page_addr;
    logic [15:0] dq_in, dq_out;
    logic dq_oe, word_valid, program_start, erase_start, lock_start;
    logic [7:0] operation_status_word;
    logic sync_burst_mode = 1'b0;
    logic [1:0] burst_len_sel = 2'h0;
    logic engine_busy = 1'b0;
    logic [6:0] flags = 7'h00;
    logic [15:0] array_word = ARRAY_WORD;
    logic [15:0] ident_word = 16'h3C5A;
    logic erase_suspended_flag, erase_result_flag, program_result_flag, program_voltage_flag;
    logic program_suspended_flag, locked_block_flag, fast_program_state_flag;
    logic [15:0] d, d2, e;
    logic v, v2;
    logic [7:0] seq_a [5] = '{CMD_PROG_SETUP, CMD_ERASE_SETUP, CMD_LOCK_SETUP, CMD_ERASE_SETUP,
        CMD_PROG_ALT};
    logic [7:0] seq_b [5] = '{8'h12, CMD_CONFIRM, 8'h01, 8'h55, 8'h34};
    // start pulse expected per sequence: 0 program, 1 erase, 2 lock, 3 none
    int seq_c [5] = '{0, 1, 2, 3, 0};
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int pcnt [3] = '{0, 0, 0};
    int ecnt [3] = '{0, 0, 0};

    // live status flags, bit 6 down to bit 0
    assign {erase_suspended_flag, erase_result_flag, program_result_flag, program_voltage_flag,
        program_suspended_flag, locked_block_flag, fast_program_state_flag} = flags;

    // 125 MHz system clock
    always #4 clk_sys = ~clk_sys;

    flash_host_model host_i (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
        .address_valid_n(address_valid_n), .burst_clk(burst_clk), .page_addr(page_addr),
        .dq_in(dq_in), .dq_out(dq_out), .word_valid(word_valid));

    flash_status_read_path flash_status_read_path_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .address_valid_n(address_valid_n),
        .burst_clk(burst_clk), .page_addr(page_addr), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .word_valid(word_valid), .sync_burst_mode(sync_burst_mode),
        .burst_len_sel(burst_len_sel), .array_data(array_word), .ident_data(ident_word),
        .engine_busy(engine_busy), .erase_suspended_flag(erase_suspended_flag),
        .erase_result_flag(erase_result_flag), .program_result_flag(program_result_flag),
        .program_voltage_flag(program_voltage_flag),
        .program_suspended_flag(program_suspended_flag),
        .locked_block_flag(locked_block_flag), .fast_program_state_flag(fast_program_state_flag),
        .program_start(program_start), .erase_start(erase_start), .lock_start(lock_start),
        .operation_status_word(operation_status_word));

    // count start pulses; each is one cycle wide so a plain edge count suffices
    always @(posedge clk_sys)
    begin
        if (program_start === 1'b1) pcnt[0]++;
        if (erase_start === 1'b1) pcnt[1]++;
        if (lock_start === 1'b1) pcnt[2]++;
    end

    // hang guard; the whole run needs well under 3000 cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            errors++;
            end_sim();
        end
    end

    // expected status word for the given live flags
    function automatic logic [15:0] st(input logic [6:0] f, input logic b);
        return {STATUS_HIGH_BYTE, ~b, f};
    endfunction : st

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        host_i.tick(2);
        chk({8'h00, operation_status_word}, 16'h0000);
        chk({15'h0, dq_oe}, 16'h0000);
        host_i.rd(2'h0, d, v, d2, v2);
        chk(d, ARRAY_WORD);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            flags <= (i < 7) ? 7'(1 << i) : 7'h00;
            engine_busy <= (i == 7);
            host_i.tick(1);
            host_i.wr(CMD_READ_STATUS, 2'(i));
            host_i.rd(2'h0, d, v, d2, v2);
            chk(d, st(flags, engine_busy));
            chk({8'h00, operation_status_word}, st(flags, engine_busy));
            chk({15'h0, v}, 16'h0001);
        end
        engine_busy <= 1'b0;
        flags <= 7'h2A;
        host_i.tick(1);
        host_i.rd(2'h1, d, v, d2, v2);
        chk(d, st(7'h2A, 1'b0));
        chk({15'h0, v2}, 16'h0000);
        // flags move after the select-fall latch, one clock after the enable pin falls but before its synchronised fall
        fork
            host_i.rd(2'h0, d, v, d2, v2);
            begin
                host_i.tick(4);
                flags <= 7'h55;
                host_i.tick(4);
                chk({15'h0, dq_oe}, 16'h0001);
            end
        join
        chk(d, st(7'h2A, 1'b0));
        chk(d2, st(7'h2A, 1'b0));
        host_i.rd(2'h0, d, v, d2, v2);
        chk(d, st(7'h55, 1'b0));
        ident_word <= 16'h1E2D;
        host_i.wr(CMD_READ_ID, 2'h2);
        host_i.rd(2'h1, d, v, d2, v2);
        chk(d, 16'h1E2D);
        chk({14'h0, v, v2}, 16'h0002);
        host_i.wr(CMD_QUERY, 2'h1);
        host_i.wr(CMD_CLEAR_STATUS, 2'h0);
        host_i.rd(2'h0, d, v, d2, v2);
        chk(d, 16'h1E2D);
        array_word <= ~ARRAY_WORD;
        host_i.wr(CMD_READ_ARRAY, 2'h3);
        host_i.rd(2'h0, d, v, d2, v2);
        chk(d, ~ARRAY_WORD);
        $display("test async status done");
        for (int k = 0; k < 5; k++)
        begin
            host_i.wr(CMD_READ_ARRAY, 2'h0);
            host_i.wr(seq_a[k], 2'h1);
            host_i.wr(seq_b[k], 2'h2);
            if (seq_c[k] < 3) ecnt[seq_c[k]]++;
            for (int j = 0; j < 3; j++) chk(16'(pcnt[j]), 16'(ecnt[j]));
            host_i.rd(2'h0, d, v, d2, v2);
            chk(d, st(7'h55, 1'b0));
        end
        $display("test command sequences done");
        sync_burst_mode <= 1'b1;
        flags <= 7'h13;
        host_i.tick(1);
        fork
            host_i.burst(6);
            begin
                host_i.tick(20);
                flags <= 7'h64;
            end
        join
        e = st(7'h13, 1'b0);
        for (int i = 0; i < 4; i++) chk(host_i.beat_q[i][15:0], e);
        for (int i = 0; i < 4; i++) chk({15'h0, host_i.beat_q[i][16]}, 16'h0001);
        chk({15'h0, host_i.beat_q[6][16]}, 16'h0000);
        burst_len_sel <= BURST_SEL_CONT;
        host_i.burst(6);
        chk(host_i.beat_q[0][15:0], st(7'h64, 1'b0));
        chk(host_i.beat_q[6], {1'b1, st(7'h64, 1'b0)});
        $display("test burst done");
        end_sim();
    end
endmodule : tb_flash_status_read_path
